// *** asp_device.sv ***
// Purpose: Serial port with shared 8-bit auto-reload bit-rate timer, APB side
// Assumes: Peer idles its line high
// Notes: Data writes while a transmit frame is in flight are ignored
// Summary of operation
// R1 - Data address: write transmits, read gives receive
// R2 - Receive shifter separate from receive buffer
// R3 - Interrupt on done flags; software clears
// R4 - Transmit clock halves low byte overflows
// R5 - Hidden receive timer shares run and reload
// R6 - Start edge reloads hidden receive timer
// R7 - Software sets auto-reload, double rate; here the timer always auto-reloads from reload_r and has no double-rate bit
// R8 - Six timer clock sources
// R9 - Width select: 0 eight, 1 nine
// R10 - Eight-bit frame: start, 8 LSB-first, stop
// R11 - Eight-bit: stop bit into ninth flag
// R12 - Buffer write starts a frame
// R13 - Transmit done at stop bit start
// R14 - Receive only while enable set
// R15 - Eight-bit accept: done clear, stop check
// R16 - Rejected frame changes nothing
// R17 - Overrun keeps first byte, drops new
// R18 - Nine-bit frame carries software ninth bit
// R19 - Nine-bit: ninth into flag, stop ignored
// R20 - Nine-bit accept: done clear, ninth check
// R21 - Master marks addresses with ninth bit
// R22 - Falling edge start, mid-bit sampling
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
module asp_device import asp_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic ext_osc_in,
  input wire logic timer_pin_in,
  output logic irq_out,
  asp_link_if.dev link
);
  // ************************
  // Register state
  // ************************
  logic [7:0] ctrl_r;
  logic [7:0] tmr_ctrl_r;
  logic [7:0] reload_r;
  logic [7:0] low_r;
  logic [7:0] rx_tmr_r;
  logic [7:0] rx_buf_r;
  logic wr_en;
  logic tx_done_set;
  logic rx_done_set;
  logic rx_accept;
  logic [7:0] rx_byte;
  logic rx_ninth;
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
  // ************************
  // APB slave
  // ************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= 1'b0;
      case (paddr_in)
        OFS_DATA: prdata_out <= {24'h0, rx_buf_r}; // R1
        OFS_CTRL: prdata_out <= {24'h0, ctrl_r};
        OFS_TMR_CTRL: prdata_out <= {24'h0, tmr_ctrl_r};
        OFS_RELOAD: prdata_out <= {24'h0, reload_r};
        OFS_LOW: prdata_out <= {24'h0, low_r};
        default: prdata_out <= 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_r <= CTRL_RESET;
      tmr_ctrl_r <= 8'h0;
      reload_r <= 8'h0;
    end else begin
      if (wr_en && paddr_in == OFS_CTRL) begin
        ctrl_r[7:2] <= {pwdata_in[7], 1'b1, pwdata_in[5:2]};
        ctrl_r[BIT_TX_DONE] <= pwdata_in[BIT_TX_DONE] | tx_done_set; // R3
        ctrl_r[BIT_RX_DONE] <= pwdata_in[BIT_RX_DONE] | rx_done_set; // R3
      end else begin
        ctrl_r[BIT_TX_DONE] <= ctrl_r[BIT_TX_DONE] | tx_done_set; // R13
        ctrl_r[BIT_RX_DONE] <= ctrl_r[BIT_RX_DONE] | rx_done_set; // R15
      end
      if (rx_accept) begin
        ctrl_r[BIT_RX_NINTH] <= rx_ninth; // R11 R19
      end
      if (wr_en && paddr_in == OFS_TMR_CTRL) begin
        tmr_ctrl_r <= {3'h0, pwdata_in[4:0]};
      end
      if (wr_en && paddr_in == OFS_RELOAD) begin
        reload_r <= pwdata_in[7:0];
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= tmr_ctrl_r[BIT_IRQ_EN] & (ctrl_r[BIT_TX_DONE] | ctrl_r[BIT_RX_DONE]); // R3
    end
  end
  // ************************
  // Timer clock sources
  // ************************
  logic [5:0] div48_r;
  logic [3:0] div12_r;
  logic [2:0] osc_cnt_r;
  logic [2:0] osc_s_r;
  logic [2:0] pin_s_r;
  logic tick;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div48_r <= 6'h0;
      div12_r <= 4'h0;
      osc_cnt_r <= 3'h0;
      osc_s_r <= 3'h0;
      pin_s_r <= 3'h7;
    end else begin
      div48_r <= (div48_r == DIV48_LAST) ? 6'h0 : div48_r + 6'h1;
      div12_r <= (div12_r == DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      osc_s_r <= {osc_s_r[1:0], ext_osc_in};
      pin_s_r <= {pin_s_r[1:0], timer_pin_in};
      if (osc_s_r[1] & ~osc_s_r[2]) begin
        osc_cnt_r <= osc_cnt_r + 3'h1;
      end
    end
  end
  always_comb begin
    case (tmr_ctrl_r[BIT_SEL_LO +: 3]) // R8
      SEL_CORE: tick = 1'b1;
      SEL_DIV4: tick = div48_r[1:0] == 2'b11;
      SEL_DIV12: tick = div12_r == DIV12_LAST;
      SEL_DIV48: tick = div48_r == DIV48_LAST;
      SEL_OSC8: tick = osc_s_r[1] & ~osc_s_r[2] & (osc_cnt_r == 3'h7);
      SEL_PIN: tick = ~pin_s_r[1] & pin_s_r[2];
      default: tick = 1'b0;
    endcase
  end
  // ************************
  // Transmit and receive timers
  // ************************
  logic run;
  logic tx_ovf;
  logic rx_ovf;
  logic tx_half_r;
  logic rx_ph_r;
  logic start_det;
  assign run = tmr_ctrl_r[BIT_RUN] & tick;
  assign tx_ovf = run & (low_r == 8'hff);
  assign rx_ovf = run & (rx_tmr_r == 8'hff) & ~start_det;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      low_r <= 8'h0;
      tx_half_r <= 1'b0;
    end else begin
      if (wr_en && paddr_in == OFS_LOW) begin
        low_r <= pwdata_in[7:0];
      end else if (run) begin
        low_r <= tx_ovf ? reload_r : low_r + 8'h1; // R4
      end
      if (tx_ovf) begin
        tx_half_r <= ~tx_half_r; // R4
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_tmr_r <= 8'h0;
      rx_ph_r <= 1'b0;
    end else begin
      if (start_det) begin
        rx_tmr_r <= reload_r; // R6
        rx_ph_r <= 1'b0;
      end else begin
        if (run) begin
          rx_tmr_r <= rx_ovf ? reload_r : rx_tmr_r + 8'h1; // R5
        end
        if (rx_ovf) begin
          rx_ph_r <= ~rx_ph_r; // R4
        end
      end
    end
  end
  // ************************
  // Transmitter
  // ************************
  logic [10:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic tx_busy_r;
  logic tx_tick;
  assign tx_tick = tx_ovf & tx_half_r;
  assign tx_done_set = tx_tick & tx_busy_r & (tx_left_r == 4'h1); // R13
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_sh_r <= 11'h7ff;
      tx_left_r <= 4'h0;
      tx_busy_r <= 1'b0;
      link.dev_tx <= 1'b1;
    end else if (wr_en && paddr_in == OFS_DATA && !tx_busy_r) begin
      tx_busy_r <= 1'b1; // R12
      if (ctrl_r[BIT_WIDTH_SEL]) begin
        tx_sh_r <= {1'b1, ctrl_r[BIT_TX_NINTH], pwdata_in[7:0], 1'b0}; // R18
        tx_left_r <= BITS_9;
      end else begin
        tx_sh_r <= {2'b11, pwdata_in[7:0], 1'b0}; // R10
        tx_left_r <= BITS_8;
      end
    end else if (tx_tick && tx_busy_r) begin
      if (tx_left_r == 4'h0) begin
        tx_busy_r <= 1'b0;
      end else begin
        link.dev_tx <= tx_sh_r[0]; // R10
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
      end
    end
  end
  // ************************
  // Receiver
  // ************************
  asp_state_type rx_st_r;
  logic [1:0] rx_s_r;
  logic rx_prev_r;
  logic [8:0] rx_sh_r;
  logic [3:0] rx_cnt_r;
  logic sample;
  logic check_bit;
  assign sample = rx_ovf & ~rx_ph_r; // R22
  assign start_det = ctrl_r[BIT_REN] & (rx_st_r == ST_IDLE) & rx_prev_r & ~rx_s_r[1]; // R14 R22
  assign rx_byte = ctrl_r[BIT_WIDTH_SEL] ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_ninth = ctrl_r[BIT_WIDTH_SEL] ? rx_sh_r[8] : rx_s_r[1]; // R11 R19
  assign check_bit = ~ctrl_r[BIT_MD_CHECK] | rx_ninth; // R15 R20
  assign rx_accept = sample & (rx_st_r == ST_STOP) & ctrl_r[BIT_REN] & // R14
    ~ctrl_r[BIT_RX_DONE] & check_bit; // R16 R17
  assign rx_done_set = rx_accept;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_s_r <= 2'b11;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s_r <= {rx_s_r[0], link.peer_tx};
      rx_prev_r <= rx_s_r[1];
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_st_r <= ST_IDLE;
      rx_sh_r <= 9'h0;
      rx_cnt_r <= 4'h0;
    end else begin
      case (rx_st_r)
        ST_IDLE: begin
          if (start_det) begin
            rx_st_r <= ST_START;
          end
        end
        ST_START: begin
          if (sample) begin
            rx_st_r <= rx_s_r[1] ? ST_IDLE : ST_DATA;
            rx_cnt_r <= 4'h0;
          end
        end
        ST_DATA: begin
          if (sample) begin
            rx_sh_r <= {rx_s_r[1], rx_sh_r[8:1]}; // R2
            rx_cnt_r <= rx_cnt_r + 4'h1;
            if (rx_cnt_r == (ctrl_r[BIT_WIDTH_SEL] ? 4'h8 : 4'h7)) begin
              rx_st_r <= ST_STOP; // R9
            end
          end
        end
        ST_STOP: begin
          if (sample) begin
            rx_st_r <= ST_IDLE;
          end
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_buf_r <= 8'h0;
    end else if (rx_accept) begin
      rx_buf_r <= rx_byte; // R2 R17
    end
  end
endmodule : asp_device

// *** asp_pkg.sv ***
// Purpose: Shared constants for the timer-clocked serial port and its peer
// Assumes: One 100 MHz core clock, APB word offsets
// Notes: Control register layout mirrors the serial control byte
package asp_pkg;
  // ************************
  // Register offsets
  // ************************
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TMR_CTRL = 8'h08;
  localparam logic [7:0] OFS_RELOAD = 8'h0c;
  localparam logic [7:0] OFS_LOW = 8'h10;
  // ************************
  // Control register fields
  // ************************
  localparam int BIT_WIDTH_SEL = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_MD_CHECK = 5;
  localparam int BIT_REN = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  // ************************
  // Timer control fields
  // ************************
  localparam int BIT_RUN = 0;
  localparam int BIT_SEL_LO = 1;
  localparam int BIT_IRQ_EN = 4;
  localparam logic [2:0] SEL_CORE = 3'h0;
  localparam logic [2:0] SEL_DIV4 = 3'h1;
  localparam logic [2:0] SEL_DIV12 = 3'h2;
  localparam logic [2:0] SEL_DIV48 = 3'h3;
  localparam logic [2:0] SEL_OSC8 = 3'h4;
  localparam logic [2:0] SEL_PIN = 3'h5;
  localparam logic [5:0] DIV48_LAST = 6'h2f;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  // ************************
  // Frame and peer timing
  // ************************
  localparam logic [3:0] BITS_8 = 4'ha;
  localparam logic [3:0] BITS_9 = 4'hb;
  localparam int PEER_BIT_CYCLES = 16;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b11,
    ST_STOP = 2'b10
  } asp_state_type;
endpackage : asp_pkg

// *** asp_link_if.sv ***
// Purpose: Serial line pair between the port and its remote peer
// Assumes: Both lines idle high
// Notes: No clocking block
`timescale 1ns/1ps
interface asp_link_if;
  logic dev_tx;
  logic peer_tx;
  modport dev (output dev_tx, input peer_tx);
  modport peer (input dev_tx, output peer_tx);
endinterface : asp_link_if

// *** asp_peer.sv ***
// Purpose: Remote serial end with fixed bit time
// Assumes: Device bit time equals PEER_BIT_CYCLES
// Notes: Start is ignored while a frame is being sent
`timescale 1ns/1ps
module asp_peer import asp_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic nine_in,
  input wire logic tx_start_in,
  input wire logic [8:0] tx_data_in,
  output logic tx_busy_out,
  output logic rx_valid_out,
  output logic [8:0] rx_data_out,
  output logic rx_stop_out,
  asp_link_if.peer link
);
  localparam logic [7:0] FULL = 8'(PEER_BIT_CYCLES - 1);
  localparam logic [7:0] HALF = 8'(PEER_BIT_CYCLES / 2 - 1);
  // ************************
  // Transmitter
  // ************************
  logic [10:0] tx_sh_r;
  logic [3:0] tx_left_r;
  logic [7:0] tx_cnt_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_sh_r <= 11'h7ff;
      tx_left_r <= 4'h0;
      tx_cnt_r <= 8'h0;
      tx_busy_out <= 1'b0;
      link.peer_tx <= 1'b1;
    end else if (!tx_busy_out) begin
      if (tx_start_in) begin
        tx_busy_out <= 1'b1;
        tx_cnt_r <= 8'h0;
        link.peer_tx <= 1'b0; // R10
        tx_sh_r <= nine_in ? {2'b11, tx_data_in} : {3'b111, tx_data_in[7:0]}; // R18 R21
        tx_left_r <= nine_in ? BITS_9 - 4'h1 : BITS_8 - 4'h1;
      end
    end else if (tx_cnt_r != FULL) begin
      tx_cnt_r <= tx_cnt_r + 8'h1;
    end else begin
      tx_cnt_r <= 8'h0;
      if (tx_left_r == 4'h0) begin
        tx_busy_out <= 1'b0;
      end else begin
        link.peer_tx <= tx_sh_r[0];
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
      end
    end
  end
  // ************************
  // Receiver
  // ************************
  asp_state_type st_r;
  logic [1:0] s_r;
  logic [8:0] sh_r;
  logic [3:0] n_r;
  logic [7:0] cnt_r;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= 2'b11;
      st_r <= ST_IDLE;
      sh_r <= 9'h0;
      n_r <= 4'h0;
      cnt_r <= 8'h0;
      rx_valid_out <= 1'b0;
      rx_data_out <= 9'h0;
      rx_stop_out <= 1'b0;
    end else begin
      s_r <= {s_r[0], link.dev_tx};
      rx_valid_out <= 1'b0;
      cnt_r <= cnt_r + 8'h1;
      case (st_r)
        ST_IDLE: begin
          cnt_r <= 8'h0;
          if (!s_r[1]) begin
            st_r <= ST_START;
          end
        end
        ST_START: begin
          if (cnt_r == HALF) begin
            cnt_r <= 8'h0;
            n_r <= 4'h0;
            st_r <= s_r[1] ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (cnt_r == FULL) begin
            cnt_r <= 8'h0;
            sh_r <= {s_r[1], sh_r[8:1]};
            n_r <= n_r + 4'h1;
            if (n_r == (nine_in ? 4'h8 : 4'h7)) begin
              st_r <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (cnt_r == FULL) begin
            st_r <= ST_IDLE;
            rx_valid_out <= 1'b1;
            rx_stop_out <= s_r[1];
            rx_data_out <= nine_in ? sh_r : {1'b0, sh_r[8:1]};
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule : asp_peer

// *** asp_link_asserts.sv ***
// Purpose: Line checks on the link between port and peer
// Assumes: 16-cycle bits, timer setup fixed once before traffic
// Notes: Sees only the two line signals
`timescale 1ns/1ps
module asp_link_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic dev_tx,
  input wire logic peer_tx
);
  // ************************
  // Helper counters
  // ************************
  logic dev_q;
  logic seen_r;
  logic [3:0] run_r;
  logic [7:0] dev_lo_r;
  logic [7:0] peer_lo_r;
  always_ff @(posedge clk_in) begin
    dev_q <= dev_tx;
    if (rst_in) begin
      seen_r <= 1'b0;
      run_r <= 4'h0;
    end else if (dev_tx != dev_q) begin
      seen_r <= 1'b1;
      run_r <= 4'h1;
    end else begin
      run_r <= run_r + 4'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_tx) dev_lo_r <= 8'h00;
    else if (dev_lo_r != 8'hff) dev_lo_r <= dev_lo_r + 8'h01;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in || peer_tx) peer_lo_r <= 8'h00;
    else if (peer_lo_r != 8'hff) peer_lo_r <= peer_lo_r + 8'h01;
  end
  // ************************
  // Assertions
  // ************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_dev_hold;
    $changed(dev_tx) |=> $stable(dev_tx)[*8] ##1 $stable(dev_tx)[*7];
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("device bit too short");
  property p_peer_hold;
    $changed(peer_tx) |=> $stable(peer_tx)[*8] ##1 $stable(peer_tx)[*7];
  endproperty
  a_peer_hold: assert property (p_peer_hold)
    else $error("peer bit too short");
  property p_dev_grid;
    (dev_tx != dev_q) && seen_r |-> run_r == 4'h0;
  endproperty
  a_dev_grid: assert property (p_dev_grid)
    else $error("device edge off bit grid");
  property p_dev_low;
    dev_lo_r <= 8'ha0;
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device line low too long");
  property p_peer_low;
    peer_lo_r <= 8'ha0;
  endproperty
  a_peer_low: assert property (p_peer_low)
    else $error("peer line low too long");
  property p_dev_idle;
    $fell(rst_in) |-> dev_tx ##1 dev_tx;
  endproperty
  a_dev_idle: assert property (p_dev_idle)
    else $error("device line not idle after reset");
  property p_peer_idle;
    $fell(rst_in) |-> peer_tx ##1 peer_tx;
  endproperty
  a_peer_idle: assert property (p_peer_idle)
    else $error("peer line not idle after reset");
  property p_start_len;
    $fell(dev_tx) && dev_lo_r == 8'h00 |-> !dev_tx[*8] ##1 !dev_tx[*7];
  endproperty
  a_start_len: assert property (p_start_len)
    else $error("device low pulse too short");
endmodule : asp_link_asserts

// *** testbench.sv ***
// Purpose: Port and peer joined back to back
// Assumes: Reload 8'hf8 on core clock gives 16-cycle bits
// Notes: APB master with pready sampled at the edge
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench import asp_pkg::*;;
  // ************************
  // Wiring
  // ************************
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic ext_tgl = 1'b0;
  logic irq;
  logic nine = 1'b0;
  logic pst = 1'b0;
  logic [8:0] pdat = 9'h000;
  logic pbusy;
  logic pval;
  logic [8:0] prx;
  logic pstop;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  asp_link_if link();
  asp_device u_asp_device(.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .ext_osc_in(ext_tgl),
    .timer_pin_in(ext_tgl), .irq_out(irq), .link(link.dev));
  asp_peer u_asp_peer(.clk_in(clk_in), .rst_in(rst_in), .nine_in(nine),
    .tx_start_in(pst), .tx_data_in(pdat), .tx_busy_out(pbusy), .rx_valid_out(pval),
    .rx_data_out(prx), .rx_stop_out(pstop), .link(link.peer));
  asp_link_asserts u_chk(.clk_in(clk_in), .rst_in(rst_in), .dev_tx(link.dev_tx),
    .peer_tx(link.peer_tx));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) ext_tgl <= ~ext_tgl;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ************************
  // Tasks
  // ************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    logic err;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    rdy = 1'b0;
    err = 1'b1;
    while (!rdy) begin
      @(posedge clk_in);
      rdy = (pready === 1'b1);
      rd = prdata;
      err = pslverr;
    end
    `CHK(rdy, 1'b1)
    `CHK(err, 1'b0)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic peer_send(input logic [8:0] d);
    @(posedge clk_in);
    pdat <= d;
    pst <= 1'b1;
    @(posedge clk_in);
    pst <= 1'b0;
    @(negedge clk_in);
    for (int i = 0; i < 300 && pbusy !== 1'b0; i++) @(negedge clk_in);
    repeat (4) @(negedge clk_in);
  endtask : peer_send
  task automatic dev_send(input logic [7:0] d, input logic [8:0] exp);
    apb(1'b1, OFS_DATA, {24'h0, d});
    for (int i = 0; i < 1000 && pval !== 1'b1; i++) @(negedge clk_in);
    `CHK(pval, 1'b1)
    `CHK(prx, exp)
    `CHK(pstop, 1'b1)
  endtask : dev_send
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // ************************
  // Tests
  // ************************
  task automatic t_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, {24'h0, CTRL_RESET})
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b1, OFS_RELOAD, 32'hf8);
    apb(1'b1, OFS_TMR_CTRL, 32'h11);
    apb(1'b0, OFS_RELOAD, 32'h0);
    `CHK(rd, 32'hf8)
    $display("t_reset done");
  endtask : t_reset
  task automatic t_tx8();
    dev_send(8'ha5, 9'h0a5);
    `CHK(irq, 1'b1)
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[BIT_TX_DONE], 1'b1)
    apb(1'b1, OFS_CTRL, 32'h50);
    repeat (2) @(negedge clk_in);
    `CHK(irq, 1'b0)
    $display("t_tx8 done");
  endtask : t_tx8
  task automatic t_rx8();
    peer_send(9'h03c);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[7:0], 8'h55)
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK(rd, 32'h3c)
    @(negedge clk_in);
    `CHK(irq, 1'b1)
    peer_send(9'h0c7);
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK(rd, 32'h3c)
    apb(1'b1, OFS_CTRL, 32'h50);
    peer_send(9'h02e);
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK(rd, 32'h2e)
    apb(1'b1, OFS_CTRL, 32'h40);
    peer_send(9'h011);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[BIT_RX_DONE], 1'b0)
    $display("t_rx8 done");
  endtask : t_rx8
  task automatic t_nine();
    @(posedge clk_in);
    nine <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'hd8);
    dev_send(8'h5a, 9'h15a);
    apb(1'b1, OFS_CTRL, 32'hf0);
    peer_send(9'h0c3);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[BIT_RX_DONE], 1'b0)
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK(rd, 32'h2e)
    peer_send(9'h1a7);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[7:0], 8'hf5)
    apb(1'b0, OFS_DATA, 32'h0);
    `CHK(rd, 32'ha7)
    $display("t_nine done");
  endtask : t_nine
  task automatic t_sel(input logic [2:0] sel, input logic [7:0] lo, input logic [7:0] hi);
    apb(1'b1, OFS_TMR_CTRL, {27'h0, 1'b1, sel, 1'b1});
    apb(1'b1, OFS_LOW, 32'h0);
    repeat (96) @(posedge clk_in);
    apb(1'b0, OFS_LOW, 32'h0);
    `CHK(rd[7:0] >= lo && rd[7:0] <= hi, 1'b1)
  endtask : t_sel
  task automatic t_timer();
    t_sel(SEL_CORE, 8'h61, 8'h61);
    t_sel(SEL_DIV4, 8'h18, 8'h19);
    t_sel(SEL_DIV12, 8'h08, 8'h09);
    t_sel(SEL_DIV48, 8'h02, 8'h03);
    t_sel(SEL_OSC8, 8'h06, 8'h07);
    t_sel(SEL_PIN, 8'h30, 8'h31);
    t_sel(3'h6, 8'h00, 8'h00);
    $display("t_timer done");
  endtask : t_timer
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_tx8();
    t_rx8();
    t_nine();
    t_timer();
    complete_run();
  end
endmodule : testbench
